/* verilog/prom_prog_pkg.sv */
// constants and types for the fuse prom programming sequencer
package prom_prog_pkg;
  localparam int unsigned CLK_MHZ        = 125;
  // times in their own units
  localparam int unsigned PULSE_SHORT_MS = 1;
  localparam int unsigned PULSE_LONG_MS  = 10;
  localparam int unsigned SETTLE_US      = 10;
  localparam int unsigned CYC_PER_US     = CLK_MHZ;
  localparam int unsigned CYC_PER_MS     = CLK_MHZ * 1000;
  localparam int unsigned SHORT_CYC      = PULSE_SHORT_MS * CYC_PER_MS;
  localparam int unsigned LONG_CYC       = PULSE_LONG_MS * CYC_PER_MS;
  localparam int unsigned SETTLE_CYC     = SETTLE_US * CYC_PER_US;
  // duty limit 35 percent: off time >= on * 65 / 35
  localparam int unsigned DUTY_NUM       = 65;
  localparam int unsigned DUTY_DEN       = 35;
  localparam int unsigned ADDR_W         = 9;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned CNT_W          = 32;
  localparam int unsigned BIT_W          = 3;
  localparam int unsigned TRY_W          = 2;
  localparam logic [TRY_W-1:0] SHORT_TRIES = 2'h2;
  localparam logic [TRY_W-1:0] MAX_TRIES   = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_ADDR    = 4'h1,
    ST_READ    = 4'h2,
    ST_CHECK   = 4'h3,
    ST_COND    = 4'h4,
    ST_BOOST   = 4'h5,
    ST_BURN    = 4'h6,
    ST_HOLD    = 4'h7,
    ST_DROP    = 4'h8,
    ST_COOL    = 4'h9,
    ST_NEXT    = 4'hA,
    ST_DONE    = 4'hB,
    ST_FAIL    = 4'hC
  } state_t;
endpackage

/* verilog/prom_programmer.sv */
// programmer controller that burns a fuse prom one bit at a time
`timescale 1ns/10ps
`default_nettype none
module prom_programmer (
  input  wire logic                              clk_i,
  input  wire logic                              reset_n_i,
  input  wire logic                              start_i,
  input  wire logic                              boost_variant_i,
  input  wire logic                              shipped_high_i,
  input  wire logic [prom_prog_pkg::ADDR_W-1:0]  last_addr_i,
  input  wire logic [prom_prog_pkg::DATA_W-1:0]  want_data_i,
  input  wire logic [prom_prog_pkg::DATA_W-1:0]  prom_data_i,
  output logic      [prom_prog_pkg::ADDR_W-1:0]  word_addr_o,
  output logic      [prom_prog_pkg::ADDR_W-1:0]  addr_drive_low_o,
  output logic                                   chip_sel_o,
  output logic                                   supply_on_o,
  output logic                                   supply_boost_o,
  output logic      [prom_prog_pkg::DATA_W-1:0]  pull_up_en_o,
  output logic      [prom_prog_pkg::DATA_W-1:0]  target_output_level_o,
  output logic      [prom_prog_pkg::DATA_W-1:0]  pulse_en_o,
  output logic                                   busy_o,
  output logic                                   done_o,
  output logic                                   fail_o
);

  prom_prog_pkg::state_t                 state_q;
  logic [prom_prog_pkg::CNT_W-1:0]       cnt_q;
  logic [prom_prog_pkg::CNT_W-1:0]       on_q;
  logic [prom_prog_pkg::BIT_W-1:0]       bit_q;
  logic [prom_prog_pkg::TRY_W-1:0]       try_q;
  logic [prom_prog_pkg::ADDR_W-1:0]      addr_q;
  logic [prom_prog_pkg::DATA_W-1:0]      read_q;
  logic                                  mode_q;
  logic                                  ship_q;
  logic                                  cs_on;

  // one-hot lane select, used for pulse and target level
  function automatic logic [prom_prog_pkg::DATA_W-1:0] lane(
    input logic [prom_prog_pkg::BIT_W-1:0] b);
    lane = {{(prom_prog_pkg::DATA_W-1){1'b0}}, 1'b1} << b;
  endfunction

  // chip-select pin level for enable/disable per variant
  function automatic logic cs_level(input logic en, input logic pulse_variant);
    cs_level = pulse_variant ? en : ~en;
  endfunction

  logic want_bit;
  logic have_bit;
  logic need_burn;
  logic [prom_prog_pkg::CNT_W-1:0] width_cyc;
  logic [prom_prog_pkg::CNT_W-1:0] cool_cyc;
  assign want_bit  = want_data_i[bit_q];
  assign have_bit  = read_q[bit_q];
  // a burned bit can only move away from the shipped level
  assign need_burn = (have_bit != want_bit) && (have_bit == ship_q);
  assign width_cyc = (try_q >= prom_prog_pkg::SHORT_TRIES) ?
                     prom_prog_pkg::CNT_W'(prom_prog_pkg::LONG_CYC) :
                     prom_prog_pkg::CNT_W'(prom_prog_pkg::SHORT_CYC);
  // off time scaled from the recorded on time keeps duty under 35 percent
  assign cool_cyc  = prom_prog_pkg::CNT_W'((64'(on_q) * prom_prog_pkg::DUTY_NUM
                     + prom_prog_pkg::DUTY_DEN - 1) / prom_prog_pkg::DUTY_DEN);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q <= prom_prog_pkg::ST_IDLE;
      cnt_q   <= '0;
      bit_q   <= '0;
      try_q   <= '0;
      addr_q  <= '0;
      read_q  <= '0;
      mode_q  <= 1'b0;
      ship_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      case (state_q)
        prom_prog_pkg::ST_IDLE: begin
          if (start_i) begin
            mode_q  <= boost_variant_i;
            ship_q  <= shipped_high_i;
            addr_q  <= '0;
            bit_q   <= '0;
            try_q   <= '0;
            cnt_q   <= '0;
            state_q <= prom_prog_pkg::ST_ADDR;
          end
        end
        prom_prog_pkg::ST_ADDR: begin
          // steady supply and address settle before reading
          if (cnt_q >= prom_prog_pkg::SETTLE_CYC) begin
            state_q <= prom_prog_pkg::ST_READ;
          end
        end
        prom_prog_pkg::ST_READ: begin
          read_q  <= prom_data_i;
          state_q <= prom_prog_pkg::ST_CHECK;
        end
        prom_prog_pkg::ST_CHECK: begin
          cnt_q <= '0;
          if (have_bit == want_bit) begin
            try_q   <= '0;
            state_q <= prom_prog_pkg::ST_NEXT;
          end else if (!need_burn || try_q == prom_prog_pkg::MAX_TRIES) begin
            state_q <= prom_prog_pkg::ST_FAIL;
          end else begin
            state_q <= prom_prog_pkg::ST_COND;
          end
        end
        prom_prog_pkg::ST_COND: begin
          // outputs off, target conditioned; then apply boost or pulse
          if (cnt_q >= prom_prog_pkg::SETTLE_CYC) begin
            cnt_q   <= '0;
            state_q <= mode_q ? prom_prog_pkg::ST_BOOST : prom_prog_pkg::ST_BURN;
          end
        end
        prom_prog_pkg::ST_BOOST: begin
          if (cnt_q >= prom_prog_pkg::SETTLE_CYC) begin
            cnt_q   <= '0;
            state_q <= prom_prog_pkg::ST_BURN;
          end
        end
        prom_prog_pkg::ST_BURN: begin
          if (cnt_q >= width_cyc - 1'b1) begin
            cnt_q   <= '0;
            try_q   <= try_q + 1'b1;
            state_q <= mode_q ? prom_prog_pkg::ST_HOLD : prom_prog_pkg::ST_COOL;
          end
        end
        prom_prog_pkg::ST_HOLD: begin
          if (cnt_q >= prom_prog_pkg::SETTLE_CYC) begin
            cnt_q   <= '0;
            state_q <= prom_prog_pkg::ST_DROP;
          end
        end
        prom_prog_pkg::ST_DROP: begin
          // supply off between pulses, then cool for the duty limit
          cnt_q   <= '0;
          state_q <= prom_prog_pkg::ST_COOL;
        end
        prom_prog_pkg::ST_COOL: begin
          if (cnt_q >= cool_cyc) begin
            cnt_q   <= '0;
            state_q <= prom_prog_pkg::ST_ADDR;
          end
        end
        prom_prog_pkg::ST_NEXT: begin
          cnt_q <= '0;
          bit_q <= bit_q + 1'b1;
          if (bit_q == prom_prog_pkg::BIT_W'(prom_prog_pkg::DATA_W - 1)) begin
            if (addr_q == last_addr_i) begin
              state_q <= prom_prog_pkg::ST_DONE;
            end else begin
              addr_q  <= addr_q + 1'b1;
              state_q <= prom_prog_pkg::ST_ADDR;
            end
          end else begin
            state_q <= prom_prog_pkg::ST_READ;
          end
        end
        prom_prog_pkg::ST_DONE,
        prom_prog_pkg::ST_FAIL: begin
          if (!start_i) begin
            state_q <= prom_prog_pkg::ST_IDLE;
          end
        end
        default: state_q <= prom_prog_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boost or pulse on-time record for duty limit
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      on_q <= '0;
    end else if (state_q == prom_prog_pkg::ST_COND) begin
      on_q <= '0;
    end else if (state_q == prom_prog_pkg::ST_BOOST || state_q == prom_prog_pkg::ST_BURN
                 || state_q == prom_prog_pkg::ST_HOLD) begin
      on_q <= on_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers, all registered
  logic in_prog;
  assign in_prog = (state_q == prom_prog_pkg::ST_COND) || (state_q == prom_prog_pkg::ST_BOOST)
                || (state_q == prom_prog_pkg::ST_BURN) || (state_q == prom_prog_pkg::ST_HOLD);
  // pin is registered: enable one cycle ahead so the device drives data at the read edge
  assign cs_on = (state_q == prom_prog_pkg::ST_BURN) ||
                 (state_q == prom_prog_pkg::ST_READ) ||
                 (state_q == prom_prog_pkg::ST_CHECK) ||
                 (state_q == prom_prog_pkg::ST_NEXT) ||
                 ((state_q == prom_prog_pkg::ST_ADDR)
                  && (cnt_q >= prom_prog_pkg::SETTLE_CYC));

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      word_addr_o           <= '0;
      addr_drive_low_o      <= '0;
      chip_sel_o            <= 1'b1;
      supply_on_o           <= 1'b0;
      supply_boost_o        <= 1'b0;
      pull_up_en_o          <= '0;
      target_output_level_o <= '0;
      pulse_en_o            <= '0;
      busy_o                <= 1'b0;
      done_o                <= 1'b0;
      fail_o                <= 1'b0;
    end else begin
      word_addr_o      <= addr_q;
      addr_drive_low_o <= ~addr_q;
      if (mode_q) begin
        chip_sel_o <= cs_level(cs_on && state_q != prom_prog_pkg::ST_IDLE, 1'b0);
      end else begin
        chip_sel_o <= cs_level(cs_on && state_q != prom_prog_pkg::ST_BURN, 1'b1);
      end
      supply_on_o    <= (state_q != prom_prog_pkg::ST_IDLE) && (state_q != prom_prog_pkg::ST_DROP)
                     && (state_q != prom_prog_pkg::ST_COOL) && (state_q != prom_prog_pkg::ST_DONE)
                     && (state_q != prom_prog_pkg::ST_FAIL);
      supply_boost_o <= mode_q && ((state_q == prom_prog_pkg::ST_BOOST)
                     || (state_q == prom_prog_pkg::ST_BURN)
                     || (state_q == prom_prog_pkg::ST_HOLD));
      pull_up_en_o          <= (mode_q && in_prog) ? ~lane(bit_q) : '0;
      target_output_level_o <= (mode_q && in_prog) ? lane(bit_q) : '0;
      pulse_en_o            <= (!mode_q && state_q == prom_prog_pkg::ST_BURN) ?
                               lane(bit_q) : '0;
      busy_o <= (state_q != prom_prog_pkg::ST_IDLE) && (state_q != prom_prog_pkg::ST_DONE)
             && (state_q != prom_prog_pkg::ST_FAIL);
      done_o <= state_q == prom_prog_pkg::ST_DONE;
      fail_o <= state_q == prom_prog_pkg::ST_FAIL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_one_pulse;
    @(posedge clk_i) disable iff (!reset_n_i) $onehot0(pulse_en_o);
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("more than one output pulsed");

  property p_one_target;
    @(posedge clk_i) disable iff (!reset_n_i)
      (target_output_level_o != '0) |-> ($onehot(target_output_level_o)
        && ((pull_up_en_o & target_output_level_o) == '0));
  endproperty
  a_one_target: assert property (p_one_target) else $error("target lane overlap");

  property p_boost_before_cs;
    @(posedge clk_i) disable iff (!reset_n_i)
      $rose(supply_boost_o) |-> chip_sel_o [*8];
  endproperty
  a_boost_before_cs: assert property (p_boost_before_cs) else $error("cs low too soon");

  property p_cs_high_at_boost;
    @(posedge clk_i) disable iff (!reset_n_i)
      $rose(supply_boost_o) |-> chip_sel_o && $past(chip_sel_o);
  endproperty
  a_cs_high_at_boost: assert property (p_cs_high_at_boost) else $error("boost with cs low");

  property p_cs_before_drop;
    @(posedge clk_i) disable iff (!reset_n_i)
      $fell(supply_boost_o) |-> $past(chip_sel_o, 8);
  endproperty
  a_cs_before_drop: assert property (p_cs_before_drop) else $error("drop too close");

  property p_boost_then_off;
    @(posedge clk_i) disable iff (!reset_n_i) $fell(supply_boost_o) |-> !supply_on_o;
  endproperty
  a_boost_then_off: assert property (p_boost_then_off) else $error("supply not removed");

  property p_no_pulse_idle;
    @(posedge clk_i) disable iff (!reset_n_i)
      (state_q == prom_prog_pkg::ST_IDLE) |=> (pulse_en_o == '0) && !supply_boost_o;
  endproperty
  a_no_pulse_idle: assert property (p_no_pulse_idle) else $error("pulse while idle");

  property p_addr_stable;
    @(posedge clk_i) disable iff (!reset_n_i)
      (pulse_en_o != '0) |-> $stable(word_addr_o) && (addr_drive_low_o == ~word_addr_o);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in pulse");

  ////////////////////////////////////////////////////////////////////////////
  // pin-level age counters, read only by the timing checks below
  logic                            burn_pin;
  logic [prom_prog_pkg::CNT_W-1:0] boost_age_q;
  logic [prom_prog_pkg::CNT_W-1:0] steady_age_q;
  logic [prom_prog_pkg::CNT_W-1:0] burn_age_q;
  // counted from the pins, not the states, so a one-cycle skew is caught
  assign burn_pin = (supply_boost_o && !chip_sel_o) || (|pulse_en_o);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      boost_age_q  <= '0;
      steady_age_q <= '0;
      burn_age_q   <= '0;
    end else begin
      boost_age_q  <= supply_boost_o ? boost_age_q + 1'b1 : '0;
      steady_age_q <= (supply_on_o && !supply_boost_o) ? steady_age_q + 1'b1 : '0;
      burn_age_q   <= burn_pin ? burn_age_q + 1'b1 : '0;
    end
  end

  property p_cs_window;
    @(posedge clk_i) disable iff (!reset_n_i)
      (supply_boost_o && $fell(chip_sel_o)) |->
        (boost_age_q >= prom_prog_pkg::SETTLE_CYC)
        && (boost_age_q <= prom_prog_pkg::CYC_PER_MS);
  endproperty
  a_cs_window: assert property (p_cs_window) else $error("cs fell outside window");

  property p_verify_settled;
    @(posedge clk_i) disable iff (!reset_n_i)
      (mode_q && !supply_boost_o && $fell(chip_sel_o)) |->
        (steady_age_q >= prom_prog_pkg::SETTLE_CYC);
  endproperty
  a_verify_settled: assert property (p_verify_settled) else $error("verify too early");

  property p_burn_width;
    @(posedge clk_i) disable iff (!reset_n_i)
      $fell(burn_pin) |->
        (burn_age_q >= prom_prog_pkg::SHORT_CYC)
        && (burn_age_q <= prom_prog_pkg::LONG_CYC);
  endproperty
  a_burn_width: assert property (p_burn_width) else $error("burn width out of range");

  c_boost: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(supply_boost_o));
  c_pulse: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(|pulse_en_o));
  c_done:  cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(done_o));
  c_fail:  cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(fail_o));

endmodule
`default_nettype wire

/* verif/fuse_prom_model.sv */
// behavioural fuse prom seen from its programming pins, with sequencing checks
`timescale 1ns/10ps
`default_nettype none
module fuse_prom_model #(
  parameter int unsigned NEED = 125000
) (
  input  wire logic       clk_i,
  input  wire logic       boost_part_i,
  input  wire logic       ship_high_i,
  input  wire logic [8:0] addr_i,
  input  wire logic       cs_i,
  input  wire logic       vcc_i,
  input  wire logic       vpp_i,
  input  wire logic [7:0] pull_i,
  input  wire logic [7:0] lvl_i,
  input  wire logic [7:0] pulse_i,
  output logic      [7:0] data_o,
  output int              viol_o,
  output int              win_o
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] opened [512];
  logic [7:0] last     = 8'h00;
  logic [7:0] lane     = 8'h00;
  logic       boosted  = 1'b0;
  int         hi_cnt   = 0;
  int         cs_hi    = 0;
  int         lo_cnt   = 0;
  int         steady   = 0;
  wire        en       = vcc_i && !vpp_i && (boost_part_i ? !cs_i : cs_i);
  wire  [7:0] word     = opened[addr_i] ^ {8{ship_high_i}};
  wire        burning  = (vpp_i && !cs_i) || (|pulse_i);
  // released outputs show the inverse so a read while disabled cannot pass
  assign data_o = en ? word : ~last;
  initial begin
    foreach (opened[i]) opened[i] = 8'h00;
    viol_o = 0;
    win_o = 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (en) last <= word;
    hi_cnt <= vpp_i ? hi_cnt + 1 : 0;
    cs_hi <= (vpp_i && cs_i) ? cs_hi + 1 : 0;
    steady <= (vcc_i && !vpp_i) ? steady + 1 : 0;
    lo_cnt <= burning ? lo_cnt + 1 : 0;
    lane <= lvl_i | pulse_i;
    if ($rose(vpp_i) && (!cs_i || $countones(lvl_i) != 1 || pull_i != ~lvl_i))
      viol_o <= viol_o + 1;
    if ($countones(pulse_i) > 1) viol_o <= viol_o + 1;
    if ($fell(cs_i) && vpp_i && (hi_cnt < 1250 || hi_cnt > 125000))
      viol_o <= viol_o + 1;
    if ($fell(vpp_i)) begin
      boosted <= 1'b1;
      if (cs_hi < 1250 || cs_hi > 125000) viol_o <= viol_o + 1;
    end
    if (boosted && steady >= 1250) boosted <= 1'b0;
    if (boosted && en && steady < 1250) viol_o <= viol_o + 1;
    if (lo_cnt > 0 && !burning) begin
      win_o <= lo_cnt;
      // fuses only ever open, never close again
      if (lo_cnt >= NEED) opened[addr_i] <= opened[addr_i] | lane;
      if (lo_cnt > 2500000) viol_o <= viol_o + 1;
    end
  end
endmodule
`default_nettype wire

/* verif/test_fuse_prom_program_sequencer.sv */
// self-checking bench for the fuse prom programmer against the prom model
`timescale 1ns/10ps
`default_nettype none
module test_fuse_prom_program_sequencer;
  ////////////////////////////////////////////////////////////////////////////////
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       start = 1'b0;
  logic       bv = 1'b0;
  logic       sh = 1'b0;
  logic [8:0] last_a = 9'h000;
  logic [7:0] want = 8'h00;
  logic [7:0] prom_data;
  logic [8:0] word_addr;
  logic [8:0] drive_low;
  logic       cs;
  logic       vcc;
  logic       vpp;
  logic [7:0] pull;
  logic [7:0] lvl;
  logic [7:0] pulse;
  logic       busy;
  logic       done;
  logic       fail;
  int         viol;
  int         win;
  int         num_errors = 0;
  int         checks_done = 0;
  int         steps = 0;
  logic       pulse_seen = 1'b0;
  logic       boost_seen = 1'b0;
  logic [8:0] prev_a = 9'h000;
  wire  [8:0] addr_inv = ~word_addr;

  prom_programmer prom_programmer_i (.clk_i(clk), .reset_n_i(reset_n), .start_i(start),
    .boost_variant_i(bv), .shipped_high_i(sh), .last_addr_i(last_a), .want_data_i(want),
    .prom_data_i(prom_data), .word_addr_o(word_addr), .addr_drive_low_o(drive_low),
    .chip_sel_o(cs), .supply_on_o(vcc), .supply_boost_o(vpp), .pull_up_en_o(pull),
    .target_output_level_o(lvl), .pulse_en_o(pulse), .busy_o(busy), .done_o(done),
    .fail_o(fail));
  fuse_prom_model fuse_prom_model_i (.clk_i(clk), .boost_part_i(bv), .ship_high_i(sh),
    .addr_i(word_addr), .cs_i(cs), .vcc_i(vcc), .vpp_i(vpp), .pull_i(pull), .lvl_i(lvl),
    .pulse_i(pulse), .data_o(prom_data), .viol_o(viol), .win_o(win));

  initial begin
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // falling edge, away from the edge that launches the registered outputs
  always @(negedge clk) begin
    if (busy === 1'b1) begin
      check("addr_drive_low_o", addr_inv, drive_low);
      if (word_addr !== prev_a) steps++;
    end
    prev_a <= word_addr;
    if (|pulse) pulse_seen = 1'b1;
    if (vpp === 1'b1) boost_seen = 1'b1;
  end

  // one programming run; start held until done or fail, then dropped
  task automatic run(input logic b, input logic h, input logic [8:0] la,
                     input logic [7:0] wd, input logic exp_fail, input int limit);
    int n;
    n = 0;
    bv = b;
    sh = h;
    last_a = la;
    want = wd;
    steps = 0;
    pulse_seen = 1'b0;
    boost_seen = 1'b0;
    start = 1'b1;
    while (done !== 1'b1 && fail !== 1'b1 && n < limit) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("fail_o", exp_fail, fail);
    check("done_o", !exp_fail, done);
    start = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("busy_o", 1'b0, busy);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (3) @(posedge clk);
    #1;
    check("chip_sel_o", 1'b1, cs);
    check("supply_on_o", 1'b0, vcc);
    check("supply_boost_o", 1'b0, vpp);
    check("pulse_en_o", 8'h00, pulse);
    check("busy_o", 1'b0, busy);
  endtask

  task automatic t_skip_pulse_part;
    run(1'b0, 1'b0, 9'h003, 8'h00, 1'b0, 20000);
    check("word_addr_o", 9'h003, word_addr);
    check("address steps", 32'd3, steps);
    check("pulse seen", 1'b0, pulse_seen);
  endtask

  task automatic t_burn_one_bit;
    run(1'b1, 1'b0, 9'h000, 8'h04, 1'b0, 600000);
    check("burned word", 8'h04, fuse_prom_model_i.opened[0]);
    check("burn window", prom_prog_pkg::SHORT_CYC, win);
    check("sequence faults", 32'd0, viol);
    check("boost seen", 1'b1, boost_seen);
    check("supply_boost_o", 1'b0, vpp);
  endtask

  task automatic t_shipped_high_and_irreversible;
    run(1'b1, 1'b1, 9'h000, 8'hFB, 1'b0, 5000);
    check("boost seen", 1'b0, boost_seen);
    run(1'b1, 1'b1, 9'h000, 8'hFF, 1'b1, 5000);
    run(1'b1, 1'b0, 9'h000, 8'h00, 1'b1, 5000);
    check("boost seen", 1'b0, boost_seen);
    check("burned word", 8'h04, fuse_prom_model_i.opened[0]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    t_reset();
    repeat (7) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_skip_pulse_part();
    t_burn_one_bit();
    t_shipped_high_and_irreversible();
    final_report();
  end

  // one burn with its cool-down is by far the longest part of the run
  initial begin
    #6000000;
    num_errors++;
    $display("watchdog expired before the tests ended");
    final_report();
  end
endmodule
`default_nettype wire
